/* File: src/mshp_defs.svh */
// constants of the serial host port: frame layout, checksum, unlock, timing
// assumes a 100 MHz system clock
`ifndef MSHP_DEFS_SVH
`define MSHP_DEFS_SVH
`define MSHP_FRAME_CLOCKS 6'd48
`define MSHP_FRAME_CHECKSUM_BIAS 8'h33
`define MSHP_UNLOCK_ADDR 7'h7F
`define MSHP_UNLOCK_WORD 32'h5A7896B4
`define MSHP_CLK_MHZ 100
`define MSHP_TIMEOUT_MS 20
`define MSHP_TIMEOUT_CYC (`MSHP_TIMEOUT_MS * 1000 * `MSHP_CLK_MHZ)
`define MSHP_IDLE3_US 400
`define MSHP_IDLE3_CYC (`MSHP_IDLE3_US * `MSHP_CLK_MHZ)
`endif

/* File: src/mshp_pkg.sv */
// types of the serial host port
// used only by the port design file; the synchroniser does not import it
package mshp_pkg;
    typedef enum logic [1:0] {MSHP_LOCKED, MSHP_IDLE, MSHP_FRAME} mshp_state_t;
endpackage

/* File: src/mshp_sync.sv */
// two-flop synchroniser for one level from outside the clock domain
// assumes sys_clk is the destination clock
`timescale 1ns/100ps
module mshp_sync (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic asyncIn,
    output logic syncOut
);
    logic meta_r;

    // first flop feeds only the second
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            meta_r <= asyncIn;
            syncOut <= meta_r;
        end
    end
endmodule

/* File: src/metering_spi_host_port.sv */
// device end of the metering serial host port: 48-clock read/write frames
// assumes serial pins are asynchronous and slow (clock well below sys_clk/4)
`timescale 1ns/100ps
`include "mshp_defs.svh"
////////////////////////////////////////////////////////////////////////////////
module metering_spi_host_port
    import mshp_pkg::*;
#(
    parameter int TIMEOUT_CYC = `MSHP_TIMEOUT_CYC,
    parameter int IDLE3_CYC = `MSHP_IDLE3_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic threeWire,
    input wire logic serial_select_n,
    input wire logic serial_clock_pin,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe,
    output logic spiActive,
    output logic spiError,
    output logic regWrite,
    output logic regRead,
    output logic [6:0] regAddr,
    output logic [31:0] regWrData,
    input wire logic [31:0] regRdData
);
    logic selSync, clkSync, dinSync;
    logic clkPrev_r;
    mshp_state_t state_r;
    logic [5:0] bitCnt_r;
    logic [47:0] shiftIn_r;
    logic [7:0] cmd_r;
    logic [39:0] resp_r;
    logic [31:0] gapCnt_r;
    logic [31:0] idleCnt_r;
    logic idleOk_r;

    mshp_sync uSel (.sys_clk(sys_clk), .resetn(resetn), .asyncIn(serial_select_n),
        .syncOut(selSync));
    mshp_sync uClk (.sys_clk(sys_clk), .resetn(resetn), .asyncIn(serial_clock_pin),
        .syncOut(clkSync));
    mshp_sync uDin (.sys_clk(sys_clk), .resetn(resetn), .asyncIn(serialDataIn),
        .syncOut(dinSync));

    ////////////////////////////////////////////////////////////////////////////
    // edge and frame decode
    logic riseEdge, fallEdge, selected, frameStart, frameEnd, timedOut;
    logic [47:0] frameBits, frameWord;
    logic [7:0] fCmd, fB0, fB1, fB2, fB3, fSum, wrSum, calcWrSum;
    logic isRead, cksOk, isUnlock, fullFrame;
    assign riseEdge = clkSync & ~clkPrev_r;
    assign fallEdge = ~clkSync & clkPrev_r;
    // 4-wire framed by select; 3-wire by long clock-low interval
    assign selected = threeWire ? 1'b1 : ~selSync;
    assign frameStart = riseEdge & selected & (threeWire ? idleOk_r : 1'b1);
    assign frameBits = {shiftIn_r[46:0], dinSync};
    // 3-wire decodes on the 48th edge, before that bit is shifted in;
    // 4-wire decodes at select rise, when the shift register already holds all 48
    assign frameWord = threeWire ? frameBits : shiftIn_r;
    assign fCmd = frameWord[47:40];
    assign fB0 = frameWord[39:32];
    assign fB1 = frameWord[31:24];
    assign fB2 = frameWord[23:16];
    assign fB3 = frameWord[15:8];
    assign fSum = frameWord[7:0];
    assign wrSum = fCmd + fB0 + fB1 + fB2 + fB3;
    assign calcWrSum = `MSHP_FRAME_CHECKSUM_BIAS + ~wrSum;
    assign cksOk = (calcWrSum == fSum);
    assign isRead = fCmd[0];
    assign isUnlock = !isRead && fCmd[7:1] == `MSHP_UNLOCK_ADDR
        && {fB3, fB2, fB1, fB0} == `MSHP_UNLOCK_WORD && cksOk;
    assign timedOut = (state_r == MSHP_FRAME) && gapCnt_r >= TIMEOUT_CYC[31:0];
    // 4-wire ends at select rise; 3-wire ends at the 48th clock
    assign frameEnd = threeWire ? (riseEdge && bitCnt_r == `MSHP_FRAME_CLOCKS - 6'd1)
        : (selSync && state_r == MSHP_FRAME);
    // a 3-wire frame closes only on its 48th edge (a stall times out instead); a 4-wire one must count 48
    assign fullFrame = threeWire || bitCnt_r == `MSHP_FRAME_CLOCKS;

    // read response: four data bytes low first, then checksum
    logic [7:0] rSum, rCks;
    assign rSum = cmd_r + regRdData[7:0] + regRdData[15:8] + regRdData[23:16]
        + regRdData[31:24];
    assign rCks = `MSHP_FRAME_CHECKSUM_BIAS + ~rSum;

    ////////////////////////////////////////////////////////////////////////////
    // clock-low idle timer for 3-wire framing
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            idleCnt_r <= 32'h0;
            idleOk_r <= 1'b0;
        end else if (clkSync) begin
            idleCnt_r <= 32'h0;
            if (riseEdge)
                idleOk_r <= 1'b0;
        end else if (idleCnt_r >= IDLE3_CYC[31:0] - 32'h1) begin
            idleOk_r <= 1'b1;
        end else begin
            idleCnt_r <= idleCnt_r + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read strobe delayed by one: register data is only promised from here on,
    // so the response is captured once in this cycle and never reloaded
    logic loadResp_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            loadResp_r <= 1'b0;
        else
            loadResp_r <= regRead;
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame engine; async reset returns to the locked (uart) state
    // locked and idle differ only in whether the port has been opened
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clkPrev_r <= 1'b0;
            state_r <= MSHP_LOCKED;
            spiActive <= 1'b0;
            spiError <= 1'b0;
            bitCnt_r <= 6'h0;
            shiftIn_r <= 48'h0;
            cmd_r <= 8'h0;
            resp_r <= 40'h0;
            gapCnt_r <= 32'h0;
            regWrite <= 1'b0;
            regRead <= 1'b0;
            regAddr <= 7'h0;
            regWrData <= 32'h0;
            serialDataOut <= 1'b0;
            serialDataOe <= 1'b0;
        end else begin
            clkPrev_r <= clkSync;
            regWrite <= 1'b0;
            regRead <= 1'b0;
            case (state_r)
                MSHP_LOCKED, MSHP_IDLE: begin
                    serialDataOe <= 1'b0;
                    if (frameStart) begin
                        state_r <= MSHP_FRAME;
                        bitCnt_r <= 6'h1;
                        shiftIn_r <= {47'h0, dinSync};
                        gapCnt_r <= 32'h0;
                    end
                end
                MSHP_FRAME: begin
                    if (timedOut) begin
                        // a stalled frame is dropped; before unlock it leaves no trace
                        state_r <= spiActive ? MSHP_IDLE : MSHP_LOCKED;
                        spiError <= spiError | spiActive;
                        serialDataOe <= 1'b0;
                    end else if (frameEnd) begin
                        serialDataOe <= 1'b0;
                        if (!spiActive) begin
                            // only a whole, correctly summed unlock write opens the port
                            if (fullFrame && isUnlock) begin
                                spiActive <= 1'b1;
                                state_r <= MSHP_IDLE;
                            end else begin
                                state_r <= MSHP_LOCKED;
                            end
                        end else begin
                            state_r <= MSHP_IDLE;
                            if (!fullFrame) begin
                                spiError <= 1'b1;
                            end else if (!isRead && cksOk) begin
                                // a bad checksum drops the write silently
                                regWrite <= 1'b1;
                                regAddr <= fCmd[7:1];
                                regWrData <= {fB3, fB2, fB1, fB0};
                            end
                        end
                    end else begin
                        gapCnt_r <= riseEdge ? 32'h0 : gapCnt_r + 32'h1;
                        if (riseEdge) begin
                            shiftIn_r <= frameBits;
                            bitCnt_r <= bitCnt_r + 6'h1;
                            if (bitCnt_r == 6'd7) begin
                                cmd_r <= frameBits[7:0];
                                regAddr <= frameBits[7:1];
                                regRead <= spiActive & frameBits[0];
                            end
                        end
                        // capture the response once, before its first bit leaves
                        if (loadResp_r)
                            resp_r <= {regRdData[7:0], regRdData[15:8], regRdData[23:16],
                                regRdData[31:24], rCks};
                        // shift out on falling edge, mode 0
                        if (fallEdge && bitCnt_r >= 6'd8 && cmd_r[0] && spiActive) begin
                            serialDataOe <= 1'b1;
                            serialDataOut <= resp_r[39];
                            resp_r <= {resp_r[38:0], 1'b0};
                        end
                    end
                end
                default: begin
                    state_r <= spiActive ? MSHP_IDLE : MSHP_LOCKED;
                    serialDataOe <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* File: tb/mshp_checker.sv */
// concurrent checks on the serial host port outputs
// assumes it is bound to the top module, all in the sys_clk domain
`timescale 1ns/100ps
module mshp_checker (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic threeWire,
    input wire logic serial_select_n,
    input wire logic serialDataOe,
    input wire logic spiActive,
    input wire logic spiError,
    input wire logic regWrite,
    input wire logic regRead
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // six cycles of select high outlasts the two-flop sync plus the output flop
    sequence s_idle;
        (!threeWire && serial_select_n) [*6];
    endsequence
    a_lock_no_oe: assert property (!spiActive |-> !serialDataOe) else $error("oe while locked");
    a_lock_no_read: assert property (!spiActive |-> !regRead) else $error("read while locked");
    a_write_one_cycle: assert property (regWrite |=> !regWrite) else $error("long write");
    a_read_one_cycle: assert property (regRead |=> !regRead) else $error("long read");
    a_active_sticky: assert property (spiActive |=> spiActive) else $error("lost active");
    a_error_sticky: assert property (spiError |=> spiError) else $error("lost error");
    a_error_when_active: assert property (spiError |-> spiActive) else $error("early error");
    a_read_drives_out: assert property (regRead |-> ##[1:40] serialDataOe) else $error("no oe");
    a_idle_tristate: assert property (s_idle |-> !serialDataOe) else $error("oe idle");
endmodule
bind metering_spi_host_port mshp_checker mshp_checker_i (.*);

/* File: tb/mshp_host_model.sv */
// host side model: sends 4-wire or 3-wire frames with an 80 ns link clock
// assumes sys_clk at 100 MHz; pins change at its falling edges only
`timescale 1ns/100ps
module mshp_host_model (
    input wire logic sys_clk,
    input wire logic hold3,
    input wire logic misoOut,
    input wire logic misoOe,
    output logic csn,
    output logic sclk,
    output logic mosi
);
    logic [47:0] rx;
    // idle pins: select high, clock low in mode 0
    initial begin
        csn = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
        rx = '0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // the leading gap serves both the frame spacing and the 3-wire clock-low start
    task automatic xfer(input logic [47:0] tx, input int n, input int stallAt);
        wait_n(5100);
        csn = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi = tx[47 - i];
            wait_n(4);
            sclk = 1'b1;
            rx = {rx[46:0], misoOe ? misoOut : 1'bx}; // undriven line reads unknown
            wait_n(4);
            sclk = 1'b0;
            if (i == stallAt) wait_n(300);
        end
        wait_n(4);
        csn = !hold3;
        wait_n(8);
    endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the serial host port driven by the host model
// assumes shortened timeout (200) and 3-wire idle (50) counts
`timescale 1ns/100ps
module tb_top;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic threeWire = 1'b0;
    logic csn, sclk, mosi, miso, oe, act, err, wr, rd;
    logic [6:0] addr, wa, ra;
    logic [31:0] wdata, wd;
    logic [31:0] rdData = 32'hA1B2C3D4;
    int failures = 0, check_count = 0, wn = 0, rn = 0, cyc = 0;
    mshp_host_model mshp_host_model_i (.sys_clk(sys_clk), .hold3(threeWire), .misoOut(miso),
        .misoOe(oe), .csn(csn), .sclk(sclk), .mosi(mosi));
    metering_spi_host_port #(.TIMEOUT_CYC(200), .IDLE3_CYC(50)) metering_spi_host_port_i (
        .sys_clk(sys_clk), .resetn(resetn), .threeWire(threeWire), .serial_select_n(csn),
        .serial_clock_pin(sclk), .serialDataIn(mosi), .serialDataOut(miso),
        .serialDataOe(oe), .spiActive(act), .spiError(err), .regWrite(wr), .regRead(rd),
        .regAddr(addr), .regWrData(wdata), .regRdData(rdData));
    initial forever #5 sys_clk = ~sys_clk;
    // record strobes; the cycle ceiling cuts a hang short
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc > 90000) begin
            failures++;
            close_out();
        end
        if (wr === 1'b1) begin
            wa <= addr;
            wd <= wdata;
            wn <= wn + 1;
        end
        if (rd === 1'b1) begin
            ra <= addr;
            rn <= rn + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // eight-bit sum, so carries fall away before the inversion
    function automatic logic [7:0] ck(input logic [39:0] b);
        return 8'h33 + ~(b[39:32] + b[31:24] + b[23:16] + b[15:8] + b[7:0]);
    endfunction
    function automatic logic [47:0] wf(input logic [6:0] a, input logic [31:0] d);
        logic [39:0] b;
        b = {a, 1'b0, d[7:0], d[15:8], d[23:16], d[31:24]};
        return {b, ck(b)};
    endfunction
    task automatic rd_check();
        mshp_host_model_i.xfer({7'h05, 1'b1, 40'h0}, 48, -1);
        chk(mshp_host_model_i.rx[39:0], {32'hD4C3B2A1, ck({8'h0B, 32'hD4C3B2A1})});
        chk(40'(ra), 40'h05);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_locked();
        mshp_host_model_i.xfer({7'h05, 1'b1, 40'h0}, 48, -1);
        mshp_host_model_i.xfer(48'hFEB496785A19, 48, -1);
        chk(40'({act, rn}), 40'h0);
        mshp_host_model_i.xfer(48'hFEB496785A18, 48, -1);
        chk(40'(act), 40'h1);
        $display("t_locked done");
    endtask
    task automatic t_write_read();
        int n0;
        n0 = wn;
        mshp_host_model_i.xfer(wf(7'h12, 32'hF1E2D3C4), 48, -1);
        chk({wa, 1'b0, wd}, {7'h12, 1'b0, 32'hF1E2D3C4});
        mshp_host_model_i.xfer(wf(7'h12, 32'h0) ^ 48'h1, 48, -1);
        chk(40'(wn - n0), 40'h1);
        rd_check();
        mshp_host_model_i.xfer(wf(7'h12, 32'h0), 40, -1);
        chk(40'(err), 40'h1);
        $display("t_write_read done");
    endtask
    task automatic t_reset_three();
        int n0;
        @(negedge sys_clk);
        resetn = 1'b0;
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        chk(40'({act, err}), 40'h0);
        n0 = rn;
        mshp_host_model_i.xfer({7'h05, 1'b1, 40'h0}, 48, -1);
        chk(40'(rn - n0), 40'h0);
        mshp_host_model_i.xfer(48'hFEB496785A18, 48, -1);
        threeWire = 1'b1;
        rd_check();
        mshp_host_model_i.xfer(wf(7'h12, 32'h0), 48, 10);
        chk(40'(err), 40'h1);
        $display("t_reset_three done");
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // reset for ten cycles, then the scenarios in order
    initial begin
        repeat (10) @(negedge sys_clk);
        resetn = 1'b1;
        t_locked();
        t_write_read();
        t_reset_three();
        close_out();
    end
endmodule
